// file: sbsd_pkg.sv
// Behaviour
// - prescaler divides bus clock by field plus one
// - divider selects 2 to 256 for bit clock
// - baud register readable and writable any time
// - unused status bits zero, status writes ignored
// - receive-full sets when a transfer completes
// - receive-full clears by status read then data read
// - tx-empty clears by status read then data write
// - data write ignored without prior armed status read
// - interrupt when tx-empty and tx enable set
// - tx-empty sets when buffer moves to shifter
// - idle write reaches shifter within two cycles
// - queued byte loads shifter after transfer ends
// - nothing queued leaves tx-empty set, nothing moves
// - mode fault sets when master sees select low
// - fault input only with master, fault enable, no output
// - mode fault clears by read then control write
// - data read gives receive buffer, write loads transmit
// - master starts transfer when byte is written
// - overrun keeps old byte, drops new byte
// - system enable off halts and resets all but the mode fault flag
// - interrupt on receive-full or mode fault when enabled
// - master select zero is slave, one is master
package sbsd_pkg;
  localparam logic [11:0] BAUD_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] DATA_OFS   = 12'h008;
  localparam logic [11:0] CTRL_OFS   = 12'h00C;
  localparam int PRESC_LSB  = 4;
  localparam int RATE_LSB   = 0;
  localparam int RXF_BIT    = 7;
  localparam int TXE_BIT    = 5;
  localparam int MODE_FAULT_FLAG_BIT   = 4;
  localparam int C_EN_BIT   = 6;
  localparam int C_TXIE_BIT = 5;
  localparam int C_MASTER_SELECT_BIT = 4;
  localparam int C_SELECT_OUTPUT_ENABLE_BIT = 1;
  localparam int C_IE_BIT   = 7;
  localparam int C_MFEN_BIT = 8;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam int BITS_PER_XFER = 8;

  typedef struct packed {
    logic en;
    logic master;
    logic faultEn;
    logic ssOutEn;
    logic txIrqEn;
    logic irqEn;
  } sbsd_ctrl_s;

  typedef enum logic [1:0] {
    SB_IDLE = 2'b00,
    SB_LOW  = 2'b01,
    SB_HIGH = 2'b11
  } sbsd_state_e;
endpackage : sbsd_pkg

// file: sbsd_baud_gen.sv
`timescale 1ns/100ps
module sbsd_baud_gen
  import sbsd_pkg::*;
(
  input  wire logic       sys_clk,    // bus clock
  input  wire logic       resetn,     // async reset, active low
  input  wire logic       run,        // count only while high
  input  wire logic [2:0] prescale,   // prescale_select
  input  wire logic [2:0] rateSel,    // rate_divider_select
  output logic            halfTick    // one pulse per half bit time
);
  logic [2:0] preCnt_q;
  logic [6:0] divCnt_q;
  logic [6:0] divTop;
  logic       preTick;

  // divider stage counts 1..128 prescaled ticks per half period
  assign divTop  = 7'((8'h01 << rateSel) - 8'h01);
  assign preTick = (preCnt_q == prescale);

  // prescaler, divide by field plus one
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) preCnt_q <= 3'h0;
    else if (!run || preTick) preCnt_q <= 3'h0;
    else preCnt_q <= preCnt_q + 3'h1;
  end

  // power-of-two stage, half-period pulse
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      divCnt_q <= 7'h00;
      halfTick <= 1'b0;
    end else begin
      halfTick <= 1'b0;
      if (!run) divCnt_q <= 7'h00;
      else if (preTick) begin
        if (divCnt_q == divTop) begin
          divCnt_q <= 7'h00;
          halfTick <= 1'b1;
        end else divCnt_q <= divCnt_q + 7'h01;
      end
    end
  end
endmodule : sbsd_baud_gen

// file: sbsd_spi_core.sv
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module sbsd_spi_core
  import sbsd_pkg::*;
(
  input  wire logic        sys_clk,   // bus clock, 100 MHz
  input  wire logic        resetn,    // async reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction
  input  wire logic [11:0] paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error, unmapped address
  output logic             irq,       // interrupt request
  output logic             sckOut,    // serial clock out (master)
  output logic             sckOe,     // serial clock drive enable
  output logic             mosiOut,   // data out
  output logic             ssOut,     // select out, active low
  input  wire logic        sckIn,     // serial clock in (slave)
  input  wire logic        miso,      // data in, master side
  input  wire logic        mosiIn,    // data in, slave side
  input  wire logic        ssInN      // select in, active low
);
  logic [7:0]  baud_q;
  sbsd_ctrl_s  ctrl_q;
  logic        rxFull_q, txEmpty_q, modeFault_q;
  logic        rxArm_q, txArm_q, mfArm_q;
  logic [7:0]  txBuf_q, rxBuf_q, shift_q;
  logic        shiftBusy_q;
  sbsd_state_e st_q;
  logic [3:0]  bitCnt_q;
  logic        sampled_q;
  logic        sckInPrev_q;
  logic        halfTick, xferDone, inBit, faultIn;
  logic        apbAcc, apbWr, apbRd;
  logic        hitBaud, hitStat, hitData, hitCtrl;
  logic        dataWrOk, loadShift, slvRise, slvFall;

  assign apbAcc  = psel && penable;
  assign apbWr   = apbAcc && pwrite;
  assign apbRd   = apbAcc && !pwrite;
  assign hitBaud = (paddr == BAUD_OFS);
  assign hitStat = (paddr == STATUS_OFS);
  assign hitData = (paddr == DATA_OFS);
  assign hitCtrl = (paddr == CTRL_OFS);

  // the fault input only counts in one pin configuration
  assign faultIn = ctrl_q.en && ctrl_q.master && ctrl_q.faultEn
                   && !ctrl_q.ssOutEn && !ssInN;
  assign dataWrOk = apbWr && hitData && txArm_q;
  // buffered byte goes to an idle shifter on the next edge
  assign loadShift = ctrl_q.en && !txEmpty_q && !shiftBusy_q
                     && !modeFault_q;
  assign inBit   = ctrl_q.master ? miso : mosiIn;
  assign slvRise = sckIn && !sckInPrev_q;
  assign slvFall = !sckIn && sckInPrev_q;
  // data pin is the shifter msb, so it moves on the shift edge itself
  assign mosiOut = shift_q[7];

  sbsd_baud_gen u_baud (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .run      (shiftBusy_q && ctrl_q.master),
    .prescale (baud_q[PRESC_LSB +: 3]),
    .rateSel  (baud_q[RATE_LSB +: 3]),
    .halfTick (halfTick)
  );

  // apb slave: zero wait states, error on unmapped address
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable
                 && !(hitBaud || hitStat || hitData || hitCtrl);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (hitBaud) prdata <= {24'h000000, baud_q};
        if (hitStat)
          prdata <= {24'h000000, rxFull_q, 1'b0, txEmpty_q,
                     modeFault_q, 4'h0};
        if (hitData) prdata <= {24'h000000, rxBuf_q};
        if (hitCtrl)
          prdata <= {23'h000000, ctrl_q.faultEn, ctrl_q.irqEn,
                     ctrl_q.en, ctrl_q.txIrqEn, ctrl_q.master,
                     2'b00, ctrl_q.ssOutEn, 1'b0};
      end
    end
  end

  // baud register, writable at any time
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) baud_q <= BAUD_RST;
    else if (apbWr && pready && hitBaud)
      baud_q <= pwdata[7:0];
  end

  // control bits
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ctrl_q <= sbsd_ctrl_s'(6'h00);
    else if (apbWr && pready && hitCtrl) begin
      ctrl_q.en      <= pwdata[C_EN_BIT];
      ctrl_q.txIrqEn <= pwdata[C_TXIE_BIT];
      ctrl_q.master  <= pwdata[C_MASTER_SELECT_BIT];
      ctrl_q.ssOutEn <= pwdata[C_SELECT_OUTPUT_ENABLE_BIT];
      ctrl_q.irqEn   <= pwdata[C_IE_BIT];
      ctrl_q.faultEn <= pwdata[C_MFEN_BIT];
    end
  end

  // read-then-access arming; a status read with the flag set arms
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxArm_q <= 1'b0;
      txArm_q <= 1'b0;
      mfArm_q <= 1'b0;
    end else if (!ctrl_q.en) begin
      rxArm_q <= 1'b0;
      txArm_q <= 1'b0;
      mfArm_q <= 1'b0;
    end else if (apbRd && pready && hitStat) begin
      rxArm_q <= rxFull_q;
      txArm_q <= txEmpty_q;
      mfArm_q <= modeFault_q;
    end else begin
      if (apbRd && pready && hitData) rxArm_q <= 1'b0;
      if (apbWr && pready && hitData) txArm_q <= 1'b0;
      if (apbWr && pready && hitCtrl) mfArm_q <= 1'b0;
    end
  end

  // transmit buffer and its empty flag; write load beats the set
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      txEmpty_q <= 1'b1;
      txBuf_q   <= 8'h00;
    end else if (!ctrl_q.en) begin
      txEmpty_q <= 1'b1;
      txBuf_q   <= 8'h00;
    end else if (dataWrOk && pready) begin
      txBuf_q   <= pwdata[7:0];
      txEmpty_q <= 1'b0;
    end else if (loadShift) begin
      txEmpty_q <= 1'b1;
    end
  end

  // receive buffer and full flag; set beats the clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rxFull_q <= 1'b0;
      rxBuf_q  <= 8'h00;
    end else if (!ctrl_q.en) begin
      rxFull_q <= 1'b0;
      rxBuf_q  <= 8'h00;
    end else if (xferDone) begin
      if (!rxFull_q || (apbRd && pready && hitData && rxArm_q))
        rxBuf_q <= shift_q;
      rxFull_q <= 1'b1;
    end else if (apbRd && pready && hitData && rxArm_q) begin
      rxFull_q <= 1'b0;
    end
  end

  // mode fault flag; set beats the clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) modeFault_q <= 1'b0;
    else if (faultIn) modeFault_q <= 1'b1;
    else if (apbWr && pready && hitCtrl && mfArm_q)
      modeFault_q <= 1'b0;
  end

  // slave clock edge detector on the synchronous input
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) sckInPrev_q <= 1'b0;
    else sckInPrev_q <= sckIn;
  end

  // shifter: master on half ticks, slave on external clock edges
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      shift_q     <= 8'h00;
      shiftBusy_q <= 1'b0;
      st_q        <= SB_IDLE;
      bitCnt_q    <= 4'h0;
      sampled_q   <= 1'b0;
      xferDone    <= 1'b0;
      sckOut      <= 1'b0;
    end else begin
      xferDone <= 1'b0;
      if (!ctrl_q.en || modeFault_q) begin
        shiftBusy_q <= 1'b0;
        st_q        <= SB_IDLE;
        bitCnt_q    <= 4'h0;
        sckOut      <= 1'b0;
      end else if (loadShift && ctrl_q.master) begin
        shift_q     <= txBuf_q;
        shiftBusy_q <= 1'b1;
        st_q        <= SB_LOW;
        bitCnt_q    <= 4'h0;
      end else if (loadShift && !ctrl_q.master) begin
        shift_q     <= txBuf_q;
        shiftBusy_q <= 1'b1;
        st_q        <= SB_LOW;
        bitCnt_q    <= 4'h0;
      end else if (shiftBusy_q) begin
        case (st_q)
          SB_LOW: begin                                // sample edge
            if (ctrl_q.master ? halfTick : slvRise) begin
              sampled_q <= inBit;
              st_q      <= SB_HIGH;
              // clock pin rises on the sample edge, not a cycle later
              sckOut    <= ctrl_q.master;
            end
          end
          SB_HIGH: begin                               // shift edge
            if (ctrl_q.master ? halfTick : slvFall) begin
              shift_q  <= {shift_q[6:0], sampled_q};
              sckOut   <= 1'b0;
              bitCnt_q <= bitCnt_q + 4'h1;
              st_q     <= SB_LOW;
              if (bitCnt_q == 4'(BITS_PER_XFER - 1)) begin
                shiftBusy_q <= 1'b0;
                st_q        <= SB_IDLE;
                xferDone    <= 1'b1;
              end
            end
          end
          default: begin
            st_q   <= SB_IDLE;
            sckOut <= 1'b0;
          end
        endcase
      end
    end
  end

  // pin and interrupt outputs, registered
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sckOe   <= 1'b0;
      ssOut   <= 1'b1;
      irq     <= 1'b0;
    end else begin
      sckOe   <= ctrl_q.en && ctrl_q.master;
      ssOut   <= !(ctrl_q.master && ctrl_q.faultEn && ctrl_q.ssOutEn
                   && shiftBusy_q);
      irq     <= ctrl_q.en && ((ctrl_q.txIrqEn && txEmpty_q)
                 || (ctrl_q.irqEn && (rxFull_q || modeFault_q)));
    end
  end
endmodule : sbsd_spi_core

// file: sbsd_spi_monitor.sv
`timescale 1ns/100ps
module sbsd_spi_monitor
  import sbsd_pkg::*;
(
  input wire logic        sys_clk,  // bus clock
  input wire logic        resetn,   // reset, active low
  input wire logic        psel,     // apb select
  input wire logic        penable,  // apb access
  input wire logic        pwrite,   // apb direction
  input wire logic [11:0] paddr,    // apb address
  input wire logic [31:0] pwdata,   // apb write data
  input wire logic [31:0] prdata,   // apb read data
  input wire logic        pready,   // apb ready
  input wire logic        irq,      // interrupt
  input wire logic        sckOut,   // serial clock
  input wire logic        sckOe     // clock drive enable
);
  logic [7:0]  baudQ;  // last baud written
  logic [8:0]  ctlQ;   // last control written
  logic [10:0] hiQ;    // cycles with clock high
  logic [10:0] halfW;  // expected half bit
  logic        wrQ;    // write completes
  assign wrQ = psel && penable && pready && pwrite;
  assign halfW = (11'(baudQ[6:4]) + 11'h1) << baudQ[2:0];
  // shadow of software settings
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      baudQ <= BAUD_RST;
      ctlQ  <= CTRL_RST;
    end else if (wrQ && paddr == BAUD_OFS) begin
      baudQ <= pwdata[7:0];
    end else if (wrQ && paddr == CTRL_OFS) begin
      ctlQ <= pwdata[8:0];
    end
  end
  // length of the high half of the serial clock
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) hiQ <= 11'h0;
    else hiQ <= sckOut ? hiQ + 11'h1 : 11'h0;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_rd(logic [11:0] ofs);
    psel && penable && pready && !pwrite && paddr == ofs;
  endsequence
  sequence s_ctl_wr;
    wrQ && paddr == CTRL_OFS;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_baud_back: assert property (s_rd(BAUD_OFS) |->
    {prdata[6:4], prdata[2:0]} == {baudQ[6:4], baudQ[2:0]})
    else $error("baud readback wrong");
  a_status_zero: assert property (s_rd(STATUS_OFS) |->
    prdata[31:8] == 24'h0 && !prdata[6] && prdata[3:0] == 4'h0)
    else $error("status spare bits set");
  a_data_width: assert property (s_rd(DATA_OFS) |->
    prdata[31:8] == 24'h0)
    else $error("data upper bits set");
  a_half_bit: assert property ($fell(sckOut) && ctlQ[C_EN_BIT] |->
    hiQ == halfW)
    else $error("half bit length wrong");
  a_irq_masked: assert property ((!ctlQ[C_EN_BIT] ||
    !(ctlQ[C_TXIE_BIT] || ctlQ[C_IE_BIT]))[*2] |-> !irq)
    else $error("irq while masked");
  a_fault_gate: assert property (s_rd(STATUS_OFS) ##0
    !(ctlQ[C_MASTER_SELECT_BIT] && ctlQ[C_MFEN_BIT] && !ctlQ[C_SELECT_OUTPUT_ENABLE_BIT])
    |-> !prdata[MODE_FAULT_FLAG_BIT])
    else $error("fault flag while gated");
  a_master_clk: assert property (s_ctl_wr |-> ##2
    sckOe == (ctlQ[C_EN_BIT] && ctlQ[C_MASTER_SELECT_BIT]))
    else $error("clock enable wrong");
endmodule : sbsd_spi_monitor

// file: sbsd_spi_peer.sv
`timescale 1ns/100ps
module sbsd_spi_peer (
  input  wire logic       sck,     // master clock
  input  wire logic       sckOe,   // clock driven
  input  wire logic       mosi,    // data from master
  input  wire logic       load,    // preload strobe
  input  wire logic [7:0] txByte,  // byte to return
  output logic            miso,    // data to master
  output logic [7:0]      rxByte,  // bits seen
  output int              nBits    // rising edges seen
);
  logic [7:0] shQ;  // outgoing shifter
  initial begin
    shQ = 8'h00;
    rxByte = 8'h00;
    nBits = 0;
  end
  // preload, then shift msb first on falling edge, inverted refill
  always @(posedge load) shQ = txByte;
  always @(negedge sck) shQ <= {shQ[6:0], ~shQ[7]};
  // sample on rising edge
  always @(posedge sck) begin
    rxByte <= {rxByte[6:0], mosi};
    nBits <= nBits + 1;
  end
  // idle line shows the inverse of the next bit
  assign miso = sckOe ? shQ[7] : ~shQ[7];
endmodule : sbsd_spi_peer

// file: sbsd_spi_core_tb.sv
`timescale 1ns/100ps
module sbsd_spi_core_tb;
  import sbsd_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ssInN = 1'b1, load = 1'b0, err;
  logic sckIn = 1'b0, mosiIn = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  peerTx = 8'h00, peerRx;
  logic pready, pslverr, irq, sckOut, sckOe, mosiOut, ssOut, miso;
  int nBits, n0, fail_count = 0, n_tests = 0;
  sbsd_spi_core u_sbsd_spi_core (.sys_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .sckOut,
    .sckOe, .mosiOut, .ssOut, .sckIn, .miso, .mosiIn, .ssInN);
  sbsd_spi_peer u_sbsd_spi_peer (.sck(sckOut), .sckOe, .mosi(mosiOut),
    .load, .txByte(peerTx), .miso, .rxByte(peerRx), .nBits);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  // one apb transfer; read data lands in rd
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdc
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rst();
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
  endtask : rst
  task automatic peer(input logic [7:0] b);
    peerTx <= b;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
  endtask : peer
  // poll status until receive-full shows
  task automatic waitRx();
    int k;
    k = 0;
    do begin
      apb(1'b0, STATUS_OFS, 32'h0);
      k++;
    end while (rd[RXF_BIT] !== 1'b1 && k < 1000);
    if (k >= 1000) fail_count++;
  endtask : waitRx
  task automatic t_regs();
    rdc(BAUD_OFS, {24'h0, BAUD_RST}, "baud reset");
    wr(BAUD_OFS, 32'h35);
    rdc(BAUD_OFS, 32'h35, "baud rw");
    wr(STATUS_OFS, 32'hFF);
    rdc(STATUS_OFS, 32'h20, "status");
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
  endtask : t_regs
  // data write with no armed status read must not start
  task automatic t_ignore();
    rst();
    wr(CTRL_OFS, 32'h50);
    wr(DATA_OFS, 32'h5A);
    n0 = nBits;
    repeat (40) @(posedge sys_clk);
    chk("no start", nBits, n0);
    rdc(STATUS_OFS, 32'h20, "no rx");
  endtask : t_ignore
  task automatic t_xfer();
    peer(8'h3C);
    rdc(STATUS_OFS, 32'h20, "armed");
    wr(DATA_OFS, 32'hA5);
    rdc(STATUS_OFS, 32'h20, "tx empty");
    waitRx();
    chk("rx full", rd, 32'hA0);
    chk("peer rx", {24'h0, peerRx}, 32'hA5);
    rdc(DATA_OFS, 32'h3C, "rx data");
    rdc(STATUS_OFS, 32'h20, "rx clear");
  endtask : t_xfer
  // queued byte follows, second byte lost to overrun
  task automatic t_queue();
    int k;
    wr(BAUD_OFS, 32'h01);
    peer(8'h3C);
    n0 = nBits;
    rdc(STATUS_OFS, 32'h20, "armed");
    wr(DATA_OFS, 32'h11);
    rdc(STATUS_OFS, 32'h20, "slot free");
    wr(DATA_OFS, 32'h22);
    rdc(STATUS_OFS, 32'h00, "slot full");
    k = 0;
    while ((nBits < n0 + 16 || sckOut !== 1'b0) && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    chk("queued", {24'h0, peerRx}, 32'h22);
    rdc(STATUS_OFS, 32'hA0, "stays empty");
    rdc(DATA_OFS, 32'h3C, "old kept");
  endtask : t_queue
  task automatic t_baud();
    logic [7:0] bauds [4] = '{8'h00, 8'h21, 8'h13, 8'h72};
    int per;
    for (int i = 0; i < 4; i++) begin
      wr(BAUD_OFS, {24'h0, bauds[i]});
      rdc(STATUS_OFS, 32'h20, "armed");
      wr(DATA_OFS, 32'h55);
      per = 0;
      while (sckOut !== 1'b1 && per < 5000) begin
        @(posedge sys_clk);
        per++;
      end
      per = 0;
      do begin
        @(posedge sys_clk);
        per++;
      end while (sckOut === 1'b1 && per < 5000);
      do begin
        @(posedge sys_clk);
        per++;
      end while (sckOut !== 1'b1 && per < 5000);
      chk("bit period", per, (32'(bauds[i][6:4]) + 1) <<
        (bauds[i][2:0] + 1));
      waitRx();
      apb(1'b0, DATA_OFS, 32'h0);
    end
  endtask : t_baud
  task automatic t_mode_fault_flag();
    wr(CTRL_OFS, 32'h1D0);
    ssInN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdc(STATUS_OFS, 32'h30, "fault set");
    chk("fault irq", {31'h0, irq}, 32'h1);
    ssInN <= 1'b1;
    wr(CTRL_OFS, 32'h1D0);
    rdc(STATUS_OFS, 32'h20, "fault clear");
    chk("irq clear", {31'h0, irq}, 32'h0);
    wr(CTRL_OFS, 32'h1D2);
    ssInN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rdc(STATUS_OFS, 32'h20, "fault gated");
    ssInN <= 1'b1;
  endtask : t_mode_fault_flag
  // slave mode shifts on the external clock, no baud ticks
  task automatic t_slave();
    logic [7:0] sb, got;
    sb = 8'h5B;
    got = 8'h00;
    wr(CTRL_OFS, 32'h40);
    rdc(STATUS_OFS, 32'h20, "slave armed");
    wr(DATA_OFS, 32'hC6);
    repeat (2) @(posedge sys_clk);
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= sb[i];
      repeat (2) @(posedge sys_clk);
      sckIn <= 1'b1;
      got[i] = mosiOut;
      repeat (2) @(posedge sys_clk);
      sckIn <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
    chk("slave out", {24'h0, got}, 32'hC6);
    waitRx();
    chk("slave full", rd, 32'hA0);
    rdc(DATA_OFS, {24'h0, sb}, "slave rx");
  endtask : t_slave
  // transmit interrupt, then disable in mid transfer
  task automatic t_halt();
    wr(CTRL_OFS, 32'h70);
    @(posedge sys_clk);
    chk("tx irq", {31'h0, irq}, 32'h1);
    wr(BAUD_OFS, 32'h13);
    rdc(STATUS_OFS, 32'h20, "armed");
    wr(DATA_OFS, 32'h99);
    repeat (20) @(posedge sys_clk);
    wr(CTRL_OFS, 32'h20);
    rdc(STATUS_OFS, 32'h20, "halted");
    chk("irq off", {31'h0, irq}, 32'h0);
    chk("sck idle", {31'h0, sckOut}, 32'h0);
  endtask : t_halt
  initial begin
    rst();
    t_regs();
    t_ignore();
    t_xfer();
    t_queue();
    t_baud();
    t_mode_fault_flag();
    t_slave();
    t_halt();
    test_done();
  end
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
endmodule : sbsd_spi_core_tb
bind sbsd_spi_core sbsd_spi_monitor u_sbsd_spi_monitor (.sys_clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .irq,
  .sckOut, .sckOe);
